/* common/timer16_map.svh */
// Purpose: offsets, field positions, reset values and fixed tops of the waveform timer
// Assumes: 32-bit classic wishbone, one register per aligned word
// Notes: definitions only
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH

`define ADDR_CONTROL_A 4'h0
`define ADDR_CONTROL_B 4'h4
`define ADDR_COMPARE_A 4'h8
`define ADDR_COMPARE_B 4'hc

`define CTRL_A_RESET 8'h00
`define CTRL_B_RESET 8'h00
`define BIT_FORCE_A 3
`define BIT_FORCE_B 2
`define BIT_MODE_HI 3

`define TOP_MAX 16'hffff
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff
`define BOTTOM 16'h0000

`endif

/* common/timer16_pkg.sv */
// Purpose: types of the waveform timer
// Assumes: nothing
// Notes: mode numbering follows the four-bit waveform mode select
package timer16_pkg;

	typedef enum logic [1:0]
	{
		WAVE_NONPWM = 2'b00,
		WAVE_FAST = 2'b01,
		WAVE_DUAL = 2'b10,
		WAVE_RESERVED = 2'b11
	} wave_kind_t;

	typedef enum logic [1:0]
	{
		TOP_SRC_FIXED = 2'b00,
		TOP_SRC_COMPARE_A = 2'b01,
		TOP_SRC_CAPTURE = 2'b10
	} top_src_t;

	typedef enum logic [1:0]
	{
		POINT_IMMEDIATE = 2'b00,
		POINT_TOP = 2'b01,
		POINT_BOTTOM = 2'b10,
		POINT_MAX = 2'b11
	} point_t;

	typedef struct packed
	{
		logic [31:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
		logic we;
		logic cyc;
		logic stb;
	} wb_req_t;

	typedef struct packed
	{
		logic [31:0] dat;
		logic ack;
	} wb_rsp_t;

	typedef struct packed
	{
		logic [1:0] out_mode_a;
		logic [1:0] out_mode_b;
		logic [1:0] mode_hi;
		logic [1:0] mode_lo;
		logic [15:0] compare_buf_a;
		logic [15:0] compare_buf_b;
		logic [15:0] compare_a;
		logic [15:0] compare_b;
		logic [15:0] counter;
		logic count_down;
		logic wave_a;
		logic wave_b;
		logic match_a_pend;
		logic match_b_pend;
		logic match_flag_a;
		logic match_flag_b;
		logic overflow_flag;
		logic ack;
		logic [31:0] rdata;
	} timer_state_t;

	typedef struct packed
	{
		logic drive_a;
		logic drive_b;
		logic oe_a;
		logic oe_b;
		logic override_a;
		logic override_b;
	} pin_out_t;

endpackage

/* rtl/timer16_waveform_mode_ctrl.sv */
// Purpose: 16-bit timer waveform mode control with compare outputs and force strobes
// Assumes: timer_tick_enable is a one-cycle pulse on core_clk from a prescaler
// Notes: capture value arrives as a port; direction bits come from the port block
//
// Function
// RULE_01 - counter is synchronous; tick enables counting, flags and buffer loads
// RULE_02 - nonzero channel output mode takes the pin from port logic
// RULE_03 - pin driven only while its direction bit selects output
// RULE_04 - non-pwm modes: 0 off, 1 toggle, 2 low, 3 high on match
// RULE_05 - fast pwm: mode 2 clear on match set at top; 3 inverse
// RULE_06 - fast pwm mode 1 toggles channel a only in waveform mode 15
// RULE_07 - fast pwm compare equal top with upper bit set: only top action
// RULE_08 - dual slope mode 1 toggles channel a only in modes 9 or 14; code toggles in 9 only, as 14 decodes as fast pwm
// RULE_09 - dual slope: mode 2 clear up-match, set down-match; 3 reverse
// RULE_10 - force compare acts only in non-pwm modes
// RULE_11 - software writes zero force bits while a pwm mode is selected
// RULE_12 - force bit write is a one-cycle strobe forcing a match now
// RULE_13 - forced compare sets no flag and never clears the counter
// RULE_14 - force bit positions always read as zero
// RULE_15 - waveform mode is low bits 1:0 plus two high bits of control b
// RULE_16 - modes 0, 4, 12: top max/compare a/capture, immediate update, flag at max
// RULE_17 - phase correct 1-3, 10, 11: buffers load at top, flag at bottom
// RULE_18 - fast pwm 5-7, 14, 15: update and flag at top; 13 reserved
// RULE_19 - modes 8, 9: top capture or compare a, update and flag at bottom
// RULE_20 - match flag set tick after equality; buffer loads at update-point tick
//
// Chosen here: the Wishbone slave port and the register offsets.
`include "timer16_map.svh"
module timer16_waveform_mode_ctrl
	import timer16_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire wb_req_t wb_req,
	output wb_rsp_t wb_rsp,
	input wire logic timer_tick_enable,
	input wire logic [15:0] capture_value,
	input wire logic dir_out_a,
	input wire logic dir_out_b,
	output pin_out_t pins,
	output logic compare_match_flag_a,
	output logic compare_match_flag_b,
	output logic overflow_flag
);

	// ==========================================================
	// state
	timer_state_t s_r;
	timer_state_t s_nxt;

	logic [3:0] waveform_mode_select;
	wave_kind_t kind;
	top_src_t top_src;
	point_t upd_point;
	point_t ovf_point;
	logic [15:0] fixed_top;
	logic [15:0] top_value;
	logic [15:0] cnt_step;
	logic at_top;
	logic at_bottom;
	logic bus_hit;
	logic bus_write;
	logic [3:0] bus_adr;

	assign waveform_mode_select = {s_r.mode_hi, s_r.mode_lo}; // RULE_15

	// ==========================================================
	// mode decode
	always_comb
	begin
		kind = WAVE_NONPWM;
		top_src = TOP_SRC_FIXED;
		upd_point = POINT_IMMEDIATE;
		ovf_point = POINT_MAX;
		fixed_top = `TOP_MAX;
		unique case (waveform_mode_select)
			4'h0:
			begin
				kind = WAVE_NONPWM; // RULE_16
			end
			4'h1, 4'h2, 4'h3:
			begin
				kind = WAVE_DUAL; // RULE_17
				upd_point = POINT_TOP;
				ovf_point = POINT_BOTTOM;
			end
			4'h4:
			begin
				top_src = TOP_SRC_COMPARE_A; // RULE_16
			end
			4'h5, 4'h6, 4'h7:
			begin
				kind = WAVE_FAST; // RULE_18
				upd_point = POINT_TOP;
				ovf_point = POINT_TOP;
			end
			4'h8, 4'h9:
			begin
				kind = WAVE_DUAL; // RULE_19
				top_src = waveform_mode_select[0] ? TOP_SRC_COMPARE_A : TOP_SRC_CAPTURE;
				upd_point = POINT_BOTTOM;
				ovf_point = POINT_BOTTOM;
			end
			4'ha, 4'hb:
			begin
				kind = WAVE_DUAL; // RULE_17
				top_src = waveform_mode_select[0] ? TOP_SRC_COMPARE_A : TOP_SRC_CAPTURE;
				upd_point = POINT_TOP;
				ovf_point = POINT_BOTTOM;
			end
			4'hc:
			begin
				top_src = TOP_SRC_CAPTURE; // RULE_16
			end
			4'hd:
			begin
				kind = WAVE_RESERVED; // RULE_18
			end
			4'he, 4'hf:
			begin
				kind = WAVE_FAST; // RULE_18
				top_src = waveform_mode_select[0] ? TOP_SRC_COMPARE_A : TOP_SRC_CAPTURE;
				upd_point = POINT_TOP;
				ovf_point = POINT_TOP;
			end
		endcase
		// low mode bits pick the fixed 8, 9 or 10 bit top
		unique case (waveform_mode_select[1:0])
			2'b01: fixed_top = `TOP_8BIT;
			2'b10: fixed_top = `TOP_9BIT;
			2'b11: fixed_top = `TOP_10BIT;
			2'b00: fixed_top = `TOP_MAX;
		endcase
		if (waveform_mode_select == 4'h0)
			fixed_top = `TOP_MAX;
	end

	always_comb
	begin
		unique case (top_src)
			TOP_SRC_COMPARE_A: top_value = s_r.compare_a;
			TOP_SRC_CAPTURE: top_value = capture_value;
			default: top_value = fixed_top;
		endcase
	end

	assign at_top = (s_r.counter == top_value);
	assign at_bottom = (s_r.counter == `BOTTOM);

	// ==========================================================
	// bus decode
	assign bus_adr = wb_req.adr[3:0];
	assign bus_hit = wb_req.cyc && wb_req.stb && !s_r.ack && (wb_req.adr[31:4] == 28'h000_0000);
	assign bus_write = bus_hit && wb_req.we && wb_req.sel[0];

	// ==========================================================
	// next state
	always_comb
	begin
		logic force_a;
		logic force_b;
		logic match_a;
		logic match_b;
		logic load_point;
		logic ovf_now;
		logic [1:0] pin_act_a;
		logic [1:0] pin_act_b;
		logic top_act;
		force_a = 1'b0;
		force_b = 1'b0;
		match_a = 1'b0;
		match_b = 1'b0;
		load_point = 1'b0;
		ovf_now = 1'b0;
		pin_act_a = 2'b00;
		pin_act_b = 2'b00;
		top_act = 1'b0;
		s_nxt = s_r;
		s_nxt.ack = bus_hit;
		s_nxt.rdata = 32'h0000_0000;

		if (bus_hit && !wb_req.we)
		begin
			unique case (bus_adr)
				`ADDR_CONTROL_A: s_nxt.rdata = {24'h00_0000, s_r.out_mode_a, s_r.out_mode_b, 2'b00, s_r.mode_lo}; // RULE_14
				`ADDR_CONTROL_B: s_nxt.rdata = {27'h000_0000, s_r.mode_hi, 3'b000};
				`ADDR_COMPARE_A: s_nxt.rdata = {16'h0000, s_r.compare_buf_a};
				`ADDR_COMPARE_B: s_nxt.rdata = {16'h0000, s_r.compare_buf_b};
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end

		if (bus_write)
		begin
			unique case (bus_adr)
				`ADDR_CONTROL_A:
				begin
					s_nxt.out_mode_a = wb_req.dat[7:6];
					s_nxt.out_mode_b = wb_req.dat[5:4];
					s_nxt.mode_lo = wb_req.dat[1:0];
					// strobes, never stored; pwm modes ignore them
					force_a = wb_req.dat[`BIT_FORCE_A] && (kind == WAVE_NONPWM); // RULE_10 RULE_12
					force_b = wb_req.dat[`BIT_FORCE_B] && (kind == WAVE_NONPWM); // RULE_10 RULE_12
				end
				`ADDR_CONTROL_B: s_nxt.mode_hi = wb_req.dat[`BIT_MODE_HI+1:`BIT_MODE_HI];
				`ADDR_COMPARE_A:
				begin
					if (wb_req.sel[1])
						s_nxt.compare_buf_a = wb_req.dat[15:0];
				end
				`ADDR_COMPARE_B:
				begin
					if (wb_req.sel[1])
						s_nxt.compare_buf_b = wb_req.dat[15:0];
				end
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// immediate-update modes pass the buffer straight through
		if (upd_point == POINT_IMMEDIATE)
		begin
			s_nxt.compare_a = s_nxt.compare_buf_a; // RULE_16
			s_nxt.compare_b = s_nxt.compare_buf_b;
		end

		if (timer_tick_enable) // RULE_01
		begin
			// flags one tick after equality
			if (s_r.match_a_pend)
				s_nxt.match_flag_a = 1'b1; // RULE_20
			if (s_r.match_b_pend)
				s_nxt.match_flag_b = 1'b1; // RULE_20
			s_nxt.match_a_pend = (s_r.counter == s_r.compare_a);
			s_nxt.match_b_pend = (s_r.counter == s_r.compare_b);
			match_a = s_nxt.match_a_pend;
			match_b = s_nxt.match_b_pend;

			unique case (upd_point)
				POINT_TOP: load_point = at_top;
				POINT_BOTTOM: load_point = at_bottom;
				default: load_point = 1'b0;
			endcase
			if (load_point)
			begin
				s_nxt.compare_a = s_r.compare_buf_a; // RULE_17 RULE_18 RULE_19 RULE_20
				s_nxt.compare_b = s_r.compare_buf_b;
			end

			unique case (ovf_point)
				POINT_MAX: ovf_now = (s_r.counter == `TOP_MAX);
				POINT_TOP: ovf_now = at_top;
				POINT_BOTTOM: ovf_now = at_bottom && s_r.count_down;
				default: ovf_now = 1'b0;
			endcase
			if (ovf_now)
				s_nxt.overflow_flag = 1'b1;

			// count sequence
			cnt_step = s_r.counter + 16'h0001;
			if (kind == WAVE_DUAL)
			begin
				if (at_top)
					s_nxt.count_down = 1'b1;
				else if (at_bottom)
					s_nxt.count_down = 1'b0;
				if (at_top || (s_r.count_down && !at_bottom))
					s_nxt.counter = s_r.counter - 16'h0001;
				else
					s_nxt.counter = cnt_step;
			end
			else if (kind == WAVE_RESERVED)
				s_nxt.counter = cnt_step;
			else
			begin
				s_nxt.count_down = 1'b0;
				s_nxt.counter = at_top ? `BOTTOM : cnt_step;
			end
			top_act = at_top && (kind == WAVE_FAST);
		end
		else
			cnt_step = s_r.counter;

		// output actions: 01 toggle, 10 clear, 11 set
		unique case (kind)
			WAVE_NONPWM:
			begin
				// a strobe written together with a new output mode acts with that new mode
				if (force_a)
					pin_act_a = s_nxt.out_mode_a; // RULE_12 RULE_13
				else if (match_a)
					pin_act_a = s_r.out_mode_a; // RULE_04
				if (force_b)
					pin_act_b = s_nxt.out_mode_b; // RULE_12 RULE_13
				else if (match_b)
					pin_act_b = s_r.out_mode_b; // RULE_04
			end
			WAVE_FAST:
			begin
				if (s_r.out_mode_a[1])
				begin
					if (top_act)
						pin_act_a = s_r.out_mode_a[0] ? 2'b10 : 2'b11; // RULE_05
					else if (match_a && (s_r.compare_a != top_value))
						pin_act_a = s_r.out_mode_a; // RULE_05 RULE_07
				end
				else if (s_r.out_mode_a[0] && (waveform_mode_select == 4'hf) && match_a)
					pin_act_a = 2'b01; // RULE_06
				if (s_r.out_mode_b[1])
				begin
					if (top_act)
						pin_act_b = s_r.out_mode_b[0] ? 2'b10 : 2'b11; // RULE_05
					else if (match_b && (s_r.compare_b != top_value))
						pin_act_b = s_r.out_mode_b; // RULE_05 RULE_07
				end
			end
			WAVE_DUAL:
			begin
				if (s_r.out_mode_a[1] && match_a)
					pin_act_a = {1'b1, s_r.out_mode_a[0] ^ s_r.count_down}; // RULE_09
				else if (s_r.out_mode_a == 2'b01 && match_a
					&& (waveform_mode_select == 4'h9 || waveform_mode_select == 4'he))
					pin_act_a = 2'b01; // RULE_08
				if (s_r.out_mode_b[1] && match_b)
					pin_act_b = {1'b1, s_r.out_mode_b[0] ^ s_r.count_down}; // RULE_09
			end
			default:
			begin
				pin_act_a = 2'b00;
				pin_act_b = 2'b00;
			end
		endcase

		unique case (pin_act_a)
			2'b01: s_nxt.wave_a = !s_r.wave_a;
			2'b10: s_nxt.wave_a = 1'b0;
			2'b11: s_nxt.wave_a = 1'b1;
			2'b00: s_nxt.wave_a = s_r.wave_a;
		endcase
		unique case (pin_act_b)
			2'b01: s_nxt.wave_b = !s_r.wave_b;
			2'b10: s_nxt.wave_b = 1'b0;
			2'b11: s_nxt.wave_b = 1'b1;
			2'b00: s_nxt.wave_b = s_r.wave_b;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			s_r <= '0;
			s_r.out_mode_a <= 2'(`CTRL_A_RESET >> 6);
		end
		else
			s_r <= s_nxt;
	end

	// ==========================================================
	// pins and outputs
	logic conn_a;
	logic conn_b;

	// fast and dual-slope mode 1 leaves channel b off, and a off outside 9/15
	always_comb
	begin
		conn_a = |s_r.out_mode_a; // RULE_02
		conn_b = |s_r.out_mode_b; // RULE_02
		if (kind == WAVE_FAST && s_r.out_mode_a == 2'b01 && waveform_mode_select != 4'hf)
			conn_a = 1'b0; // RULE_06
		if (kind == WAVE_DUAL && s_r.out_mode_a == 2'b01
			&& waveform_mode_select != 4'h9 && waveform_mode_select != 4'he)
			conn_a = 1'b0; // RULE_08
		if ((kind == WAVE_FAST || kind == WAVE_DUAL) && s_r.out_mode_b == 2'b01)
			conn_b = 1'b0;
		if (kind == WAVE_RESERVED)
		begin
			conn_a = 1'b0;
			conn_b = 1'b0;
		end
	end

	assign pins.drive_a = s_r.wave_a;
	assign pins.drive_b = s_r.wave_b;
	assign pins.override_a = conn_a;
	assign pins.override_b = conn_b;
	assign pins.oe_a = conn_a && dir_out_a; // RULE_03
	assign pins.oe_b = conn_b && dir_out_b; // RULE_03

	assign wb_rsp.ack = s_r.ack;
	assign wb_rsp.dat = s_r.rdata;
	assign compare_match_flag_a = s_r.match_flag_a;
	assign compare_match_flag_b = s_r.match_flag_b;
	assign overflow_flag = s_r.overflow_flag;

endmodule

/* dv/timer16_waveform_mode_ctrl_assertions.sv */
// Purpose: port checks of the waveform timer
// Assumes: one clock, sync reset
// Notes: bound to the top module
module timer16_waveform_mode_ctrl_assertions
	import timer16_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire wb_req_t wb_req,
	input wire wb_rsp_t wb_rsp,
	input wire logic timer_tick_enable,
	input wire logic [15:0] capture_value,
	input wire logic dir_out_a,
	input wire logic dir_out_b,
	input wire pin_out_t pins,
	input wire logic compare_match_flag_a,
	input wire logic compare_match_flag_b,
	input wire logic overflow_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	chk_oe_a_dir: assert property (pins.oe_a == (pins.override_a && dir_out_a))
		else $error("pin a enable wrong");
	chk_oe_b_dir: assert property (pins.oe_b == (pins.override_b && dir_out_b))
		else $error("pin b enable wrong");
	chk_force_reads_zero: assert property ((wb_rsp.ack && !wb_req.we && wb_req.adr == 32'h0000_0000)
		|-> wb_rsp.dat[3:2] == 2'h0) else $error("force bits read back");
	chk_flag_a_tick: assert property ($rose(compare_match_flag_a) |-> $past(timer_tick_enable))
		else $error("flag a without tick");
	chk_flag_b_tick: assert property ($rose(compare_match_flag_b) |-> $past(timer_tick_enable))
		else $error("flag b without tick");
	chk_ovf_tick: assert property ($rose(overflow_flag) |-> $past(timer_tick_enable))
		else $error("overflow without tick");
	chk_drive_cause: assert property ($changed(pins.drive_a) |-> $past(timer_tick_enable) || wb_rsp.ack)
		else $error("pin a moved without cause");
	chk_ack_answer: assert property ((wb_req.cyc && wb_req.stb && !wb_rsp.ack) |=> wb_rsp.ack)
		else $error("no ack");
	cover property (pins.oe_a && pins.drive_a);
	cover property ($rose(overflow_flag));
	cover property (wb_rsp.ack && wb_req.we);
endmodule

bind timer16_waveform_mode_ctrl timer16_waveform_mode_ctrl_assertions chk_i
(
	.core_clk(core_clk),
	.reset(reset),
	.wb_req(wb_req),
	.wb_rsp(wb_rsp),
	.timer_tick_enable(timer_tick_enable),
	.capture_value(capture_value),
	.dir_out_a(dir_out_a),
	.dir_out_b(dir_out_b),
	.pins(pins),
	.compare_match_flag_a(compare_match_flag_a),
	.compare_match_flag_b(compare_match_flag_b),
	.overflow_flag(overflow_flag)
);

/* dv/port_pin_model.sv */
// Purpose: port pins with direction bits and pull-ups
// Assumes: port value used while the timer does not own the pin
// Notes: behavioural
module port_pin_model
	import timer16_pkg::*;
(
	input wire pin_out_t pins,
	input wire logic port_a,
	input wire logic port_b,
	input wire logic dir_a,
	input wire logic dir_b,
	output logic pad_a,
	output logic pad_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// pads
	// an input pad rises on its pull-up, never keeps a stale level
	assign pad_a = pins.oe_a ? pins.drive_a : (dir_a ? port_a : 1'b1);
	assign pad_b = pins.oe_b ? pins.drive_b : (dir_b ? port_b : 1'b1);
endmodule

/* dv/timer16_waveform_mode_ctrl_tb.sv */
// Purpose: self-checking bench of the waveform timer
// Assumes: tick held high means one tick per clock
// Notes: flags have no clear path, so counting cases reset first
module timer16_waveform_mode_ctrl_tb import timer16_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// harness
	logic core_clk, reset, tick, dir_a, dir_b, port_a, port_b, fa, fb, ovf, pad_a, pad_b;
	wb_req_t wb_req;
	wb_rsp_t wb_rsp;
	pin_out_t pins;
	logic [15:0] cap;
	int error_cnt, checked, cyc_cnt;

	timer16_waveform_mode_ctrl uut
	(
		.core_clk(core_clk),
		.reset(reset),
		.wb_req(wb_req),
		.wb_rsp(wb_rsp),
		.timer_tick_enable(tick),
		.capture_value(cap),
		.dir_out_a(dir_a),
		.dir_out_b(dir_b),
		.pins(pins),
		.compare_match_flag_a(fa),
		.compare_match_flag_b(fb),
		.overflow_flag(ovf)
	);
	port_pin_model pads
	(
		.pins(pins),
		.port_a(port_a),
		.port_b(port_b),
		.dir_a(dir_a),
		.dir_b(dir_b),
		.pad_a(pad_a),
		.pad_b(pad_b)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cyc_cnt++;
		if (cyc_cnt == 30000)
		begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w, output logic [31:0] q);
		@(posedge core_clk);
		wb_req <= '{adr: {24'h00_0000, a}, dat: d, sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
		do @(posedge core_clk); while (wb_rsp.ack !== 1'b1);
		q = wb_rsp.dat;
		wb_req <= '0;
	endtask

	task automatic do_reset();
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
	endtask

	// ====
	// scenarios
	task automatic s_reset_values();
		logic [31:0] q;
		for (int i = 0; i < 5; i++)
		begin
			// last pass reads an unmapped word inside the decoded window
			xfer((i < 4) ? 8'(i * 4) : 8'h06, 32'h0000_0000, 1'b0, q);
			chk(q, 32'h0000_0000);
		end
	endtask

	task automatic s_mode_override();
		logic [31:0] q;
		logic ova, ovb, np;
		for (int m = 0; m < 16; m++)
		begin
			np = (m == 0) || (m == 4) || (m == 12);
			ova = np || (m == 9) || (m == 15);
			ovb = np;
			dir_b <= m[0];
			xfer(8'h04, {27'h000_0000, m[3:2], 3'h0}, 1'b1, q);
			xfer(8'h00, {24'h00_0000, 4'h5, 2'h0, m[1:0]}, 1'b1, q);
			@(negedge core_clk);
			chk(pins.override_a, ova);
			chk(pins.override_b, ovb);
			chk(pad_a, !ova);
			chk(pad_b, !(ovb && m[0]));
			xfer(8'h04, 32'h0000_0000, 1'b0, q);
			chk(q, {27'h000_0000, m[3:2], 3'h0});
		end
	endtask

	task automatic s_force();
		logic [31:0] q;
		logic [1:0] om [4] = '{2'h3, 2'h1, 2'h2, 2'h1};
		logic ex [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		do_reset();
		for (int k = 0; k < 4; k++)
		begin
			xfer(8'h00, {24'h00_0000, om[k], om[k], 4'hc}, 1'b1, q);
			@(negedge core_clk);
			chk(pins.drive_a, ex[k]);
			chk(pins.drive_b, ex[k]);
			xfer(8'h00, 32'h0000_0000, 1'b0, q);
			chk(q, {24'h00_0000, om[k], om[k], 4'h0});
			chk({fa, fb}, 2'h0);
		end
		xfer(8'h04, 32'h0000_0008, 1'b1, q);
		// enter fast pwm mode 5 first, then strobe both force bits
		xfer(8'h00, 32'h0000_00a1, 1'b1, q);
		xfer(8'h00, 32'h0000_00ad, 1'b1, q);
		@(negedge core_clk);
		chk({pins.drive_a, pins.drive_b}, 2'h3);
	endtask

	task automatic s_pwm_duty();
		logic [31:0] q;
		int hi_a, hi_b;
		int md [7] = '{5, 5, 5, 1, 1, 4, 14};
		int om [7] = '{2, 3, 2, 2, 3, 1, 2};
		int cv [7] = '{64, 64, 255, 64, 64, 64, 64};
		int win [7] = '{256, 256, 256, 510, 510, 130, 257};
		int exh [7] = '{65, 191, 256, 128, 382, 65, 65};
		logic ov [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		for (int k = 0; k < 7; k++)
		begin
			do_reset();
			xfer(8'h08, 32'(cv[k]), 1'b1, q);
			xfer(8'h0c, 32'(cv[k]), 1'b1, q);
			xfer(8'h04, 32'(md[k] / 4 * 8), 1'b1, q);
			xfer(8'h00, 32'(om[k] * 80 + md[k] % 4), 1'b1, q);
			@(posedge core_clk);
			tick <= 1'b1;
			// long warm-up so buffered compares have loaded at an update point
			repeat (1100) @(posedge core_clk);
			hi_a = 0;
			hi_b = 0;
			repeat (win[k])
			begin
				@(posedge core_clk);
				hi_a += pins.drive_a;
				hi_b += pins.drive_b;
			end
			chk(32'(hi_a), 32'(exh[k]));
			chk(32'(hi_b), 32'(exh[k]));
			chk(ovf, ov[k]);
			chk(fa, 1'b1);
			chk(fb, 1'b1);
			tick <= 1'b0;
		end
	endtask

	initial
	begin
		reset = 1'b1;
		tick = 1'b0;
		wb_req = '0;
		cap = 16'h0100;
		dir_a = 1'b1;
		dir_b = 1'b0;
		port_a = 1'b1;
		port_b = 1'b1;
		error_cnt = 0;
		checked = 0;
		cyc_cnt = 0;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		s_reset_values();
		s_mode_override();
		s_force();
		s_pwm_duty();
		print_verdict();
	end
endmodule
